// >>> logic/asu_serial_unit.sv
// Implementation choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/10ps
module asu_serial_unit (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic [15:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   input wire logic ext_base_tick_i,
   input wire logic serial_in_pin_i,
   output logic serial_out_pin_o,
   output logic tx_done_irq_o,
   output logic rx_done_irq_o
);
   logic [7:0] serial_mode_reg; // power, enables, parity, length, stops
   logic [7:0] baud_divider_reg; // base select and divider k
   logic [7:0] rx_buffer_reg; // last received character
   logic [2:0] rx_error_status_reg; // parity, framing, overrun
   logic rx_buf_full; // buffer holds an unread character
   logic unit_power_enable;
   logic tx_direction_enable;
   logic rx_direction_enable;
   asu_pkg::asu_parity_t par_mode;
   logic len8; // eight character bits
   logic two_stop; // two stop bits on transmit
   logic [4:0] k_value;
   logic [1:0] base_sel;
   logic base_tick; // one-clock enable at the base clock rate
   logic [4:0] presc; // free prescaler
   logic wr_mode, wr_baud, wr_tx, rd_buf, rd_stat;

   assign unit_power_enable = serial_mode_reg[asu_pkg::MODE_POWER_BIT];
   assign tx_direction_enable = serial_mode_reg[asu_pkg::MODE_TXEN_BIT];
   assign rx_direction_enable = serial_mode_reg[asu_pkg::MODE_RXEN_BIT];
   assign par_mode = asu_pkg::asu_parity_t'(serial_mode_reg[asu_pkg::MODE_PAR_LSB +: 2]);
   assign len8 = serial_mode_reg[asu_pkg::MODE_LEN_BIT];
   assign two_stop = serial_mode_reg[asu_pkg::MODE_STOP_BIT];
   assign k_value = baud_divider_reg[asu_pkg::BAUD_K_LSB +: asu_pkg::BAUD_K_WIDTH];
   assign base_sel = baud_divider_reg[asu_pkg::BAUD_SEL_LSB +: 2];
   assign wr_mode = wr_i && (addr_i == asu_pkg::ADDR_MODE);
   assign wr_baud = wr_i && (addr_i == asu_pkg::ADDR_BAUD);
   assign wr_tx = wr_i && (addr_i == asu_pkg::ADDR_TXSHIFT);
   assign rd_buf = rd_i && (addr_i == asu_pkg::ADDR_RXBUF);
   assign rd_stat = rd_i && (addr_i == asu_pkg::ADDR_ERRSTAT);

   // configuration registers; bit 0 of the mode register always reads one
   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         serial_mode_reg <= asu_pkg::MODE_RESET;
         baud_divider_reg <= asu_pkg::BAUD_RESET;
      end
      else
      begin
         if (wr_mode)
         begin
            serial_mode_reg <= {wdata_i[7:1], 1'b1};
         end
         if (wr_baud)
         begin
            baud_divider_reg <= {wdata_i[7:6], 1'b0, wdata_i[4:0]};
         end
      end
   end

   // prescaler; the base clock stands still while unpowered
   // base clock stop
   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         presc <= '0;
      end
      else if (!unit_power_enable)
      begin
         presc <= '0;
      end
      else
      begin
         presc <= presc + 5'h01;
      end
   end

   // base clock selector shared by both counters
   // common clock selector
   always_comb
   begin
      case (base_sel)
         2'h0: base_tick = ext_base_tick_i;
         2'h1: base_tick = ((presc & asu_pkg::PRESC_DIV2) == asu_pkg::PRESC_DIV2);
         2'h2: base_tick = ((presc & asu_pkg::PRESC_DIV8) == asu_pkg::PRESC_DIV8);
         default: base_tick = ((presc & asu_pkg::PRESC_DIV32) == asu_pkg::PRESC_DIV32);
      endcase
      base_tick = base_tick && unit_power_enable;
   end

   // ---------------- receive input conditioning ----------------
   logic rx_meta, rx_sync; // pin synchroniser
   logic samp_a, samp_b; // two successive base-clock samples
   logic rx_line, rx_line_prev; // filtered line and its last value

   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         rx_meta <= 1'b1;
         rx_sync <= 1'b1;
      end
      else
      begin
         rx_meta <= serial_in_pin_i;
         rx_sync <= rx_meta;
      end
   end

   // noise filter: the line only moves when two samples agree
   // match detector
   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         samp_a <= 1'b1;
         samp_b <= 1'b1;
         rx_line <= 1'b1;
      end
      else if (!unit_power_enable)
      begin
         samp_a <= 1'b1;
         samp_b <= 1'b1;
         rx_line <= 1'b1;
      end
      else if (base_tick)
      begin
         samp_a <= rx_sync;
         samp_b <= samp_a;
         if (samp_a == samp_b)
         begin
            rx_line <= samp_a;
         end
      end
   end

   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         rx_line_prev <= 1'b1;
      end
      else
      begin
         rx_line_prev <= rx_line;
      end
   end

   // ---------------- transmitter ----------------
   typedef enum {ASU_TX_IDLE, ASU_TX_RUN} asu_tx_state_t;
   asu_tx_state_t tx_state;
   logic [11:0] tx_shift_reg; // frame being sent, bit 0 on the pin
   logic [3:0] tx_left; // bits still to send including current
   logic tx_phase; // second half of the bit time
   logic tx_half; // half-bit pulse from the tx counter
   logic tx_run; // direction powered and enabled
   logic [11:0] next_frame;
   logic [3:0] next_len;
   logic [7:0] tx_data;

   assign tx_run = unit_power_enable && tx_direction_enable;

   // frame builder
   // frame layout
   always_comb
   begin
      tx_data = len8 ? wdata_i : {1'b0, wdata_i[6:0]};
      next_frame = 12'hFFF;
      next_frame[0] = 1'b0;
      for (int i = 0; i < 8; i++)
      begin
         if (i < 7 || len8)
         begin
            next_frame[i+1] = tx_data[i];
         end
      end
      next_len = len8 ? 4'h9 : 4'h8;
      case (par_mode)
         asu_pkg::ASU_PAR_EVEN: next_frame[next_len] = ^tx_data;
         asu_pkg::ASU_PAR_ODD: next_frame[next_len] = ~^tx_data;
         asu_pkg::ASU_PAR_ZERO: next_frame[next_len] = 1'b0;
         default: next_frame[next_len] = 1'b1;
      endcase
      if (par_mode != asu_pkg::ASU_PAR_NONE)
      begin
         next_len = next_len + 4'h1;
      end
      next_len = next_len + (two_stop ? 4'h2 : 4'h1);
   end

   asu_baud_counter #(.WIDTH(asu_pkg::BAUD_K_WIDTH)) u_tx_cnt (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .clear_i(!tx_run || tx_state == ASU_TX_IDLE),
      .tick_i(base_tick),
      .k_i(k_value),
      .half_o(tx_half)
   );

   // transmit sequencer: two half pulses per bit give base/(2k)
   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         tx_state <= ASU_TX_IDLE;
         tx_shift_reg <= 12'hFFF;
         tx_left <= 4'h0;
         tx_phase <= 1'b0;
         tx_done_irq_o <= 1'b0;
      end
      else if (!tx_run)
      begin
         tx_state <= ASU_TX_IDLE;
         tx_shift_reg <= 12'hFFF;
         tx_left <= 4'h0;
         tx_phase <= 1'b0;
         tx_done_irq_o <= 1'b0;
      end
      else
      begin
         tx_done_irq_o <= 1'b0;
         case (tx_state)
            ASU_TX_IDLE:
            begin
               if (wr_tx)
               begin
                  tx_shift_reg <= next_frame;
                  tx_left <= next_len;
                  tx_phase <= 1'b0;
                  tx_state <= ASU_TX_RUN;
               end
            end
            ASU_TX_RUN:
            begin
               if (tx_half)
               begin
                  tx_phase <= !tx_phase;
                  if (tx_phase)
                  begin
                     tx_shift_reg <= {1'b1, tx_shift_reg[11:1]};
                     tx_left <= tx_left - 4'h1;
                     if (tx_left == 4'h1)
                     begin
                        tx_done_irq_o <= 1'b1;
                        tx_state <= ASU_TX_IDLE;
                     end
                  end
               end
            end
            default: tx_state <= ASU_TX_IDLE;
         endcase
      end
   end

   // the pin idles high from power-on, before transmit is enabled
   // idle high
   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         serial_out_pin_o <= 1'b1;
      end
      else
      begin
         serial_out_pin_o <= (tx_state == ASU_TX_RUN) ? tx_shift_reg[0] : 1'b1;
      end
   end

   // ---------------- receiver ----------------
   typedef enum {ASU_RX_IDLE, ASU_RX_START, ASU_RX_DATA, ASU_RX_STOP} asu_rx_state_t;
   asu_rx_state_t rx_state;
   logic [7:0] rx_shift_reg; // character bits, shifted in from the top
   logic [3:0] rx_idx; // bits taken so far in this frame
   logic rx_par_bit; // received parity bit
   logic rx_phase;
   logic rx_half;
   logic rx_run;
   logic rx_sample; // bit-centre strobe
   logic [3:0] rx_nbits; // data plus parity bits expected
   logic [7:0] rx_char; // aligned received character
   logic par_err, frame_err, over_err;

   assign rx_run = unit_power_enable && rx_direction_enable;
   assign rx_sample = rx_half && rx_phase;
   assign rx_nbits = (len8 ? 4'h8 : 4'h7) + ((par_mode == asu_pkg::ASU_PAR_NONE) ? 4'h0 : 4'h1);
   assign rx_char = len8 ? rx_shift_reg : {1'b0, rx_shift_reg[7:1]};

   asu_baud_counter #(.WIDTH(asu_pkg::BAUD_K_WIDTH)) u_rx_cnt (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .clear_i(!rx_run || rx_state == ASU_RX_IDLE),
      .tick_i(base_tick),
      .k_i(k_value),
      .half_o(rx_half)
   );

   // errors judged when the single stop bit is sampled
   // three error causes
   always_comb
   begin
      case (par_mode)
         asu_pkg::ASU_PAR_EVEN: par_err = (^rx_char) ^ rx_par_bit;
         asu_pkg::ASU_PAR_ODD: par_err = ~((^rx_char) ^ rx_par_bit);
         default: par_err = 1'b0;
      endcase
      frame_err = !rx_line;
      over_err = rx_buf_full && !rd_buf;
   end

   // receive sequencer
   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         rx_state <= ASU_RX_IDLE;
         rx_shift_reg <= asu_pkg::ZERO_BYTE;
         rx_idx <= 4'h0;
         rx_par_bit <= 1'b0;
         rx_phase <= 1'b0;
      end
      else if (!rx_run)
      begin
         rx_state <= ASU_RX_IDLE;
         rx_shift_reg <= asu_pkg::ZERO_BYTE;
         rx_idx <= 4'h0;
         rx_phase <= 1'b0;
      end
      else
      begin
         if (rx_half)
         begin
            rx_phase <= !rx_phase;
         end
         case (rx_state)
            ASU_RX_IDLE:
            begin
               if (rx_line_prev && !rx_line)
               begin
                  rx_state <= ASU_RX_START;
               end
            end
            ASU_RX_START:
            begin
               if (rx_half)
               begin
                  rx_phase <= 1'b0;
                  rx_idx <= 4'h0;
                  if (!rx_line)
                  begin
                     rx_state <= ASU_RX_DATA;
                  end
                  else
                  begin
                     rx_state <= ASU_RX_IDLE;
                  end
               end
            end
            ASU_RX_DATA:
            begin
               if (rx_sample)
               begin
                  if (rx_idx < (len8 ? 4'h8 : 4'h7))
                  begin
                     rx_shift_reg <= {rx_line, rx_shift_reg[7:1]};
                  end
                  else
                  begin
                     rx_par_bit <= rx_line;
                  end
                  rx_idx <= rx_idx + 4'h1;
                  if (rx_idx + 4'h1 == rx_nbits)
                  begin
                     rx_state <= ASU_RX_STOP;
                  end
               end
            end
            ASU_RX_STOP:
            begin
               if (rx_sample)
               begin
                  rx_state <= ASU_RX_IDLE;
               end
            end
            default: rx_state <= ASU_RX_IDLE;
         endcase
      end
   end

   logic rx_complete; // stop bit sampled this cycle
   assign rx_complete = rx_run && rx_state == ASU_RX_STOP && rx_sample;

   // receive buffer and its full flag; completion wins over a read
   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         rx_buffer_reg <= asu_pkg::ZERO_BYTE;
         rx_buf_full <= 1'b0;
      end
      else if (!unit_power_enable)
      begin
         rx_buffer_reg <= asu_pkg::ZERO_BYTE;
         rx_buf_full <= 1'b0;
      end
      else if (rx_complete && !over_err)
      begin
         rx_buffer_reg <= rx_char;
         rx_buf_full <= 1'b1;
      end
      else if (rd_buf)
      begin
         rx_buf_full <= 1'b0;
      end
   end

   // error status: sticky, cleared by its read, new errors win
   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         rx_error_status_reg <= 3'h0;
      end
      else if (!unit_power_enable)
      begin
         rx_error_status_reg <= 3'h0;
      end
      else if (rx_complete)
      begin
         rx_error_status_reg[asu_pkg::ERR_PARITY_BIT] <= par_err ||
            (rx_error_status_reg[asu_pkg::ERR_PARITY_BIT] && !rd_stat);
         rx_error_status_reg[asu_pkg::ERR_FRAME_BIT] <= frame_err ||
            (rx_error_status_reg[asu_pkg::ERR_FRAME_BIT] && !rd_stat);
         rx_error_status_reg[asu_pkg::ERR_OVERRUN_BIT] <= over_err ||
            (rx_error_status_reg[asu_pkg::ERR_OVERRUN_BIT] && !rd_stat);
      end
      else if (rd_stat)
      begin
         rx_error_status_reg <= 3'h0;
      end
   end

   // completion pulse doubles as the error interrupt
   // error raises receive irq
   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         rx_done_irq_o <= 1'b0;
      end
      else
      begin
         rx_done_irq_o <= rx_complete;
      end
   end

   // read port: data one cycle after the strobe, unmapped reads zero
   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         rdata_o <= asu_pkg::ZERO_BYTE;
      end
      else if (rd_i)
      begin
         case (addr_i)
            asu_pkg::ADDR_MODE: rdata_o <= serial_mode_reg;
            asu_pkg::ADDR_BAUD: rdata_o <= baud_divider_reg;
            asu_pkg::ADDR_RXBUF: rdata_o <= rx_buffer_reg;
            asu_pkg::ADDR_ERRSTAT: rdata_o <= {5'h00, rx_error_status_reg};
            default: rdata_o <= asu_pkg::ZERO_BYTE;
         endcase
      end
      else
      begin
         rdata_o <= asu_pkg::ZERO_BYTE;
      end
   end
endmodule

// >>> common/asu_pkg.sv
package asu_pkg;
   // register addresses on the plain register port
   localparam logic [15:0] ADDR_MODE = 16'hFF70;
   localparam logic [15:0] ADDR_BAUD = 16'hFF71;
   localparam logic [15:0] ADDR_TXSHIFT = 16'hFF72;
   localparam logic [15:0] ADDR_RXBUF = 16'hFF73;
   localparam logic [15:0] ADDR_ERRSTAT = 16'hFF74;
   // reset values
   localparam logic [7:0] MODE_RESET = 8'h01;
   localparam logic [7:0] BAUD_RESET = 8'h1F;
   localparam logic [7:0] ZERO_BYTE = 8'h00;
   // mode register fields
   localparam int MODE_POWER_BIT = 7;
   localparam int MODE_TXEN_BIT = 6;
   localparam int MODE_RXEN_BIT = 5;
   localparam int MODE_PAR_LSB = 3;
   localparam int MODE_LEN_BIT = 2;
   localparam int MODE_STOP_BIT = 1;
   // baud register fields
   localparam int BAUD_SEL_LSB = 6;
   localparam int BAUD_K_LSB = 0;
   localparam int BAUD_K_WIDTH = 5;
   // error status bits
   localparam int ERR_PARITY_BIT = 2;
   localparam int ERR_FRAME_BIT = 1;
   localparam int ERR_OVERRUN_BIT = 0;
   // divider range
   localparam int K_MIN = 8;
   localparam int K_MAX = 31;
   // prescaler taps for base clock selection
   localparam logic [4:0] PRESC_DIV2 = 5'h01;
   localparam logic [4:0] PRESC_DIV8 = 5'h07;
   localparam logic [4:0] PRESC_DIV32 = 5'h1F;
   // parity mode codes
   typedef enum logic [1:0] {
      ASU_PAR_NONE = 2'h0,
      ASU_PAR_ZERO = 2'h1,
      ASU_PAR_ODD = 2'h2,
      ASU_PAR_EVEN = 2'h3
   } asu_parity_t;
endpackage

// >>> logic/asu_baud_counter.sv
`timescale 1ns/10ps
// one 5-bit divider of the baud generator: pulses once every k base ticks
module asu_baud_counter #(
   parameter int WIDTH = 5
) (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic clear_i,
   input wire logic tick_i,
   input wire logic [WIDTH-1:0] k_i,
   output logic half_o
);
   // the divider needs at least two bits to count a sensible k
   initial
   begin
      if (WIDTH < 2)
      begin
         $error("asu_baud_counter: WIDTH must be at least 2");
      end
   end

   logic [WIDTH-1:0] count; // base ticks seen in this half bit
   logic [WIDTH-1:0] next_count; // count plus one
   logic at_end; // last tick of the half bit

   assign next_count = count + {{(WIDTH-1){1'b0}}, 1'b1};
   assign at_end = tick_i && (next_count == k_i);

   // counter: held at zero while cleared, wraps after k ticks
   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         count <= '0;
      end
      else if (clear_i)
      begin
         count <= '0;
      end
      else if (at_end)
      begin
         count <= '0;
      end
      else if (tick_i)
      begin
         count <= next_count;
      end
   end

   // half-bit pulse, one clock long; two of them make one bit time
   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         half_o <= 1'b0;
      end
      else
      begin
         half_o <= at_end && !clear_i;
      end
   end
endmodule

// >>> bench/asu_link_monitor.sv
`timescale 1ns/10ps
// passive watch on the register port and the serial pins
module asu_link_monitor (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic [15:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [7:0] rdata_o,
   input wire logic ext_base_tick_i,
   input wire logic serial_in_pin_i,
   input wire logic serial_out_pin_o,
   input wire logic tx_done_irq_o,
   input wire logic rx_done_irq_o
);
   logic [7:0] mode; // shadow of the mode register
   logic busy; // a frame is on its way out
   default clocking @(posedge clk_i); endclocking
   default disable iff (reset_i);
   // one register read
   sequence rd_at(logic [15:0] a);
      rd_i && addr_i == a;
   endsequence
   // a transmit write the unit must accept
   sequence tx_go;
      wr_i && addr_i == asu_pkg::ADDR_TXSHIFT && mode[7] && mode[6] && !busy;
   endsequence
   // shadow state, rebuilt from the port alone so it cannot share a bug
   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         mode <= asu_pkg::MODE_RESET;
         busy <= 1'b0;
      end
      else
      begin
         if (wr_i && addr_i == asu_pkg::ADDR_MODE)
            mode <= wdata_i;
         if (tx_done_irq_o)
            busy <= 1'b0;
         else if (wr_i && addr_i == asu_pkg::ADDR_TXSHIFT && mode[7] && mode[6])
            busy <= 1'b1;
      end
   end
   err_clear_a: assert property (rd_at(asu_pkg::ADDR_ERRSTAT) ##1
      rd_i && addr_i == asu_pkg::ADDR_ERRSTAT && !rx_done_irq_o |=> rdata_o == 8'h00 || rx_done_irq_o)
      else $error("status not cleared by read");
   tx_frame_a: assert property (tx_go |-> ##[1:4] $fell(serial_out_pin_o) ##1 (!serial_out_pin_o)[*8])
      else $error("start bit missing");
   tx_early_a: assert property (tx_go |=> (!tx_done_irq_o)[*8])
      else $error("done before frame");
   idle_high_a: assert property (mode[7] && !busy |-> serial_out_pin_o)
      else $error("output not idle high");
   done_high_a: assert property (tx_done_irq_o |-> serial_out_pin_o ##1 (!tx_done_irq_o)[*8])
      else $error("bad transmit done pulse");
   rx_pulse_a: assert property (rx_done_irq_o |=> (!rx_done_irq_o)[*8])
      else $error("bad receive pulse");
   power_quiet_a: assert property ((!mode[7])[*3] |-> !rx_done_irq_o && !tx_done_irq_o)
      else $error("activity while unpowered");
   txreg_ro_a: assert property (rd_at(asu_pkg::ADDR_TXSHIFT) |=> rdata_o == 8'h00)
      else $error("transmit register readable");
endmodule
bind asu_serial_unit asu_link_monitor i_mon (.clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i),
   .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .ext_base_tick_i(ext_base_tick_i),
   .serial_in_pin_i(serial_in_pin_i), .serial_out_pin_o(serial_out_pin_o),
   .tx_done_irq_o(tx_done_irq_o), .rx_done_irq_o(rx_done_irq_o));

// >>> bench/asu_remote_model.sv
`timescale 1ns/10ps
// remote transmitter feeding the unit's serial input; line idles high
module asu_remote_model #(
   parameter int BIT_CLKS = 32
) (
   input wire logic clk_i,
   output logic line_o
);
   initial line_o = 1'b1;
   // levels go out first entry first, one bit time each
   task automatic send(input logic [11:0] bits, input int n);
      for (int i = 0; i < n; i++)
      begin
         @(posedge clk_i);
         line_o <= bits[i];
         repeat (BIT_CLKS - 1) @(posedge clk_i);
      end
      @(posedge clk_i);
      line_o <= 1'b1;
   endtask
   // short low pulse, far shorter than a start bit
   task automatic glitch(input int n);
      @(posedge clk_i);
      line_o <= 1'b0;
      repeat (n) @(posedge clk_i);
      line_o <= 1'b1;
   endtask
endmodule

// >>> bench/async_serial_uart_core_tb_top.sv
`timescale 1ns/10ps
module async_serial_uart_core_tb_top;
   logic clk_i;
   logic reset_i;
   logic [15:0] addr_i;
   logic [7:0] wdata_i;
   logic wr_i;
   logic rd_i;
   logic ext_base_tick_i; // external base tick, every second clock like select 01
   logic [7:0] rdata_o;
   logic serial_out_pin_o;
   logic tx_done_irq_o;
   logic rx_done_irq_o;
   wire logic line; // peer output into the unit
   int n_fail;
   int tests_run;
   int n_rx; // receive pulses seen
   asu_serial_unit i_dut (.clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .ext_base_tick_i(ext_base_tick_i),
      .serial_in_pin_i(line), .serial_out_pin_o(serial_out_pin_o), .tx_done_irq_o(tx_done_irq_o),
      .rx_done_irq_o(rx_done_irq_o));
   asu_remote_model i_peer (.clk_i(clk_i), .line_o(line));
   always #10 clk_i = ~clk_i;
   // external base source toggles so select 00 keeps the same bit time
   always @(posedge clk_i) ext_base_tick_i <= reset_i ? 1'b0 : !ext_base_tick_i;
   always @(posedge clk_i) if (rx_done_irq_o === 1'b1) n_rx++;
   task automatic step(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      tests_run++;
      if (g !== e)
      begin
         n_fail++;
         $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask
   // read with the answer taken in the cycle after the strobe
   task automatic rchk(input logic [15:0] a, input logic [7:0] e);
      @(posedge clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1;
      chk(rdata_o, e);
   endtask
   // two status reads back to back: the second must find it cleared
   task automatic rstat(input logic [7:0] e);
      @(posedge clk_i);
      addr_i <= asu_pkg::ADDR_ERRSTAT;
      rd_i <= 1'b1;
      step(1);
      chk(rdata_o, e);
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1;
      chk(rdata_o, 8'h00);
   endtask
   // line levels of one frame for mode byte m, start bit first
   function automatic logic [11:0] frame(input logic [7:0] d, input logic [7:0] m);
      logic [11:0] f;
      logic p;
      f = m[2] ? {3'h7, d, 1'b0} : {4'hF, d[6:0], 1'b0};
      p = ^(d & (m[2] ? 8'hFF : 8'h7F));
      if (m[4:3] != asu_pkg::ASU_PAR_NONE)
         f[m[2] ? 9 : 8] = m[4:3] == asu_pkg::ASU_PAR_EVEN ? p : (m[4:3] == asu_pkg::ASU_PAR_ODD ? ~p : 1'b0);
      return f;
   endfunction
   function automatic int flen(input logic [7:0] m);
      return 9 + m[2] + (m[4:3] != asu_pkg::ASU_PAR_NONE) + m[1];
   endfunction
   task automatic t_regs();
      rchk(asu_pkg::ADDR_MODE, asu_pkg::MODE_RESET);
      rchk(asu_pkg::ADDR_BAUD, asu_pkg::BAUD_RESET);
      wr(16'hFF7F, 8'hFF);
      rchk(16'hFF7F, asu_pkg::ZERO_BYTE);
      rchk(asu_pkg::ADDR_TXSHIFT, asu_pkg::ZERO_BYTE);
      wr(asu_pkg::ADDR_BAUD, 8'hFF);
      rchk(asu_pkg::ADDR_BAUD, 8'hDF);
      wr(asu_pkg::ADDR_BAUD, 8'h48);
      wr(asu_pkg::ADDR_MODE, 8'h80);
      rchk(asu_pkg::ADDR_MODE, 8'h81);
      wr(asu_pkg::ADDR_TXSHIFT, 8'h00);
      step(40);
      chk(serial_out_pin_o, 8'h01);
   endtask
   task automatic t_tx(input logic [7:0] m, input logic [7:0] d);
      logic [11:0] f;
      int i;
      f = frame(d, m);
      wr(asu_pkg::ADDR_MODE, m);
      wr(asu_pkg::ADDR_TXSHIFT, d);
      for (i = 0; i < 8 && serial_out_pin_o !== 1'b0; i++)
         step(1);
      for (i = 0; i < flen(m); i++)
      begin
         step(i > 0 ? 32 : 16);
         chk(serial_out_pin_o, f[i]);
      end
      for (i = 0; i < 24 && tx_done_irq_o !== 1'b1; i++)
         step(1);
      chk({tx_done_irq_o, i > 13}, 8'h03);
   endtask
   // r[0] reads status, r[1] then reads the buffer
   task automatic t_rx(input logic [7:0] m, d, input logic [11:0] x, input logic [7:0] es, eb,
      input logic [1:0] r);
      int c;
      c = n_rx;
      wr(asu_pkg::ADDR_MODE, m);
      i_peer.send(frame(d, m) ^ x, flen(m));
      chk(8'(n_rx - c), 8'h01);
      if (r[0])
         rstat(es);
      if (r[1])
         rchk(asu_pkg::ADDR_RXBUF, eb);
   endtask
   task automatic t_noise();
      int c;
      c = n_rx;
      i_peer.glitch(8);
      step(600);
      chk(8'(n_rx - c), 8'h00);
   endtask
   task automatic t_power();
      int c;
      t_rx(8'hE5, 8'h5A, 12'h200, 8'h00, 8'h00, 2'b00);
      wr(asu_pkg::ADDR_MODE, 8'h01);
      rchk(asu_pkg::ADDR_ERRSTAT, 8'h00);
      rchk(asu_pkg::ADDR_RXBUF, 8'h00);
      c = n_rx;
      // power returns while the pin is still low: the held-high line must show a fall
      fork
         i_peer.send(12'h000, 10);
         begin
            step(200);
            chk(8'(n_rx - c), 8'h00);
            wr(asu_pkg::ADDR_MODE, 8'hE5);
         end
      join
      step(400);
      chk(8'(n_rx - c), 8'h01);
   endtask
   task automatic final_report();
      $display("checks=%0d mismatches=%0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // the whole run needs under ten thousand cycles
   initial
   begin
      repeat (50000) @(posedge clk_i);
      n_fail++;
      final_report();
   end
   initial
   begin
      clk_i = 1'b0;
      reset_i = 1'b1;
      addr_i = 16'h0000;
      wdata_i = 8'h00;
      wr_i = 1'b0;
      rd_i = 1'b0;
      repeat (20) @(posedge clk_i);
      reset_i <= 1'b0;
      t_regs();
      t_tx(8'hFD, 8'h57);
      t_tx(8'hF3, 8'h36);
      t_tx(8'hE5, 8'h87);
      wr(asu_pkg::ADDR_BAUD, 8'h08);
      t_tx(8'hEF, 8'hA7);
      wr(asu_pkg::ADDR_BAUD, 8'h48);
      t_noise();
      t_rx(8'hFD, 8'hA5, 12'h000, 8'h00, 8'hA5, 2'b11);
      t_rx(8'hFD, 8'hA5, 12'h200, 8'h04, 8'hA5, 2'b11);
      t_rx(8'hF3, 8'h36, 12'h100, 8'h04, 8'h36, 2'b11);
      t_rx(8'hEF, 8'h0F, 12'h200, 8'h00, 8'h0F, 2'b11);
      t_rx(8'hE5, 8'h87, 12'h200, 8'h02, 8'h87, 2'b11);
      t_rx(8'hE5, 8'hC3, 12'h000, 8'h00, 8'h00, 2'b01);
      t_rx(8'hE5, 8'h3C, 12'h000, 8'h01, 8'hC3, 2'b11);
      t_power();
      final_report();
   end
endmodule
